// [rtl/fcb_top.sv]
// Flow control frame buffer: egress queues, pause logic, ingress, counters.
// Assumes host, line and MACsec logic share clk_i.
// Contract
// (R1) Pause waits for frame boundary; timer starts on entry.
// (R2) Paused: no data drain, writes go on.
// (R3) Paused state raises pause request if merged.
// (R4) Data fill vs XOFF/XON drives the request.
// (R5) One jumbo stays free after XOFF.
// (R6) Reaction enable gates pause entry and timer.
// (R7) Request enable gates all XON/XOFF.
// (R8) Merge clear: thresholds only.
// (R9) Control queue served first at frame boundary.
// (R10) Control frames pass while paused.
// (R11) Control queue enable; bounds split memory.
// (R12) Advanced mode: request enable only.
// (R13) Egress holds four max-size frames.
// (R14) Buffers absorb line/host rate offset.
// (R15) Fault and LPI words pass in band.
// (R16) MACsec back-pressure; gap widened by expansion.
// (R17) EEE machine enters LPI and wakes.
// (R18) Ingress room for host pause insertion.
// (R19) 32-bit drop counters wrap to zero.
// (R20) Control queue: overflow, underflow counts.
// (R21) Data queue: overflow, underflow counts.
// (R22) Ingress: overflow, underflow, ECC counts.
// (R23) Check bits; bad read-back aborts, counts.
// (R24) Sticky bits with mask drive interrupt.
// (R25) Host MAC pauses while request is high.
// (R26) Quanta are 512 bit times.
// (R27) Timer counts down, reloads, ends at zero.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcb_top
   import fcb_pkg::*;
#(
   parameter int EG_DEPTH = EG_DEPTH_DEF,
   parameter int ING_DEPTH = ING_DEPTH_DEF
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire fcb_word_s eg_in_i,
   input wire logic eg_in_valid_i,
   output fcb_word_s eg_out_o,
   output logic eg_out_valid_o,
   input wire logic macsec_ready_i,
   input wire logic [7:0] macsec_expand_i,
   input wire logic rx_pause_valid_i,
   input wire logic [15:0] rx_pause_quanta_i,
   output logic pause_frame_request_o,
   output logic lpi_o,
   input wire fcb_word_s ing_in_i,
   input wire logic ing_in_valid_i,
   output fcb_word_s ing_out_o,
   output logic ing_out_valid_o,
   input wire logic ing_ready_i,
   output logic irq_o
);
   localparam int EAW = $clog2(EG_DEPTH);
   localparam int IAW = $clog2(ING_DEPTH);
   localparam int MW = $bits(fcb_word_s) + 1;
   localparam int TW = FW + $clog2(PAUSE_CYC) + 1;

   // Index 0 of each pair is the data queue, index 1 the control queue
   typedef struct packed {
      logic [7:0] cfg;
      logic [EAW:0] xoff;
      logic [EAW:0] xon;
      logic [EAW:0] cut;
      logic [1:0][EAW-1:0] qs;
      logic [1:0][EAW-1:0] qe;
      logic [1:0][EAW-1:0] wp;
      logic [1:0][EAW-1:0] rp;
      logic [1:0][EAW:0] fill;
      logic [1:0][FW-1:0] frm;
      logic [1:0] wdrop;
      logic [1:0] skip;
      logic wq;
      logic sel;
      logic in_frm;
      logic [IAW-1:0] iwp;
      logic [IAW-1:0] irp;
      logic [IAW:0] ifill;
      logic [FW-1:0] ifrm;
      logic iwdrop;
      logic iskip;
      logic iin;
      logic pend;
      logic paused;
      logic [FW-1:0] pq;
      logic [TW-1:0] timer;
      logic thr;
      logic req;
      logic [7:0] gap;
      fcb_eee_e eee;
      logic [FW-1:0] ecnt;
      logic [FW-1:0] idle_thr;
      logic [FW-1:0] wake_thr;
      fcb_word_s eo;
      logic eov;
      fcb_word_s io;
      logic iov;
      logic [NCNT-1:0] sticky;
      logic [NCNT-1:0] mask;
      logic [NCNT-1:0][31:0] cnt;
      logic [31:0] rdata;
   } fcb_state_s;

   fcb_state_s s_ff;
   fcb_state_s nxt_s;
   logic [MW-1:0] eg_mem [EG_DEPTH];
   logic [MW-1:0] ing_mem [ING_DEPTH];
   logic e_we;
   logic i_we;
   logic [EAW-1:0] e_wa;
   logic [IAW-1:0] i_wa;
   logic [MW-1:0] e_wd;
   logic [MW-1:0] i_wd;
   logic [NCNT-1:0] inc;
   logic [1:0][EAW:0] qsz;
   logic [1:0][EAW:0] qfr;
   logic [1:0] st;
   logic [1:0] wr_d;
   logic [1:0] rd_d;
   logic [1:0] wr_f;
   logic [1:0] rd_f;
   logic wq;
   logic drop;
   logic rgo;
   logic rq;
   logic iwr;
   logic ird;
   logic iwf;
   logic irf;
   logic [EAW:0] lim;
   logic [EAW:0] xe;
   logic [IAW:0] ifr;
   logic [MW-1:0] w;

   function automatic logic [EAW-1:0] enx(input logic [EAW-1:0] p,
         input logic [EAW-1:0] e, input logic [EAW-1:0] s);
      return (p == e) ? s : p + 1'b1;
   endfunction

   // Top bit is even parity over the word; odd read-back means corrupt
   function automatic logic [MW-1:0] enc(input fcb_word_s d,
         input logic inj);
      return {(^d) ^ inj, d};
   endfunction

   function automatic fcb_word_s dec(input logic [MW-1:0] m);
      return fcb_word_s'(m[MW-2:0]);
   endfunction

   always_comb begin
      nxt_s = s_ff;
      inc = '0;
      e_we = 1'b0;
      e_wa = '0;
      e_wd = '0;
      i_we = 1'b0;
      i_wa = '0;
      i_wd = '0;
      wr_d = '0;
      rd_d = '0;
      wr_f = '0;
      rd_f = '0;
      wq = 1'b0;
      drop = 1'b0;
      rgo = 1'b0;
      rq = s_ff.sel;
      iwr = 1'b0;
      ird = 1'b0;
      iwf = 1'b0;
      irf = 1'b0;
      w = '0;
      for (int q = 0; q < 2; q++) begin
         qsz[q] = (EAW+1)'(s_ff.qe[q] - s_ff.qs[q]) + 1'b1; // [R11]
         qfr[q] = qsz[q] - s_ff.fill[q];
         st[q] = !s_ff.skip[q] && (s_ff.frm[q] != '0 ||
            (s_ff.cut != '0 && s_ff.fill[q] >= s_ff.cut));
      end
      ifr = (IAW+1)'(ING_DEPTH) - s_ff.ifill;

      if (wr_i) begin
         case (addr_i)
            R_CFG: nxt_s.cfg = wdata_i[7:0];
            R_XOFF: nxt_s.xoff = (EAW+1)'(wdata_i[FW-1:0]);
            R_XON: nxt_s.xon = (EAW+1)'(wdata_i[FW-1:0]);
            R_CUT: nxt_s.cut = (EAW+1)'(wdata_i[FW-1:0]);
            R_EEE: begin
               nxt_s.idle_thr = wdata_i[FW-1:0];
               nxt_s.wake_thr = wdata_i[2*FW-1:FW];
            end
            R_MASK: nxt_s.mask = wdata_i[NCNT-1:0];
            default: ;
         endcase
      end

      // Egress fill: a frame is admitted only with room for a whole
      // jumbo (control: one max control frame) so XOFF lag is absorbed
      if (eg_in_valid_i) begin
         wq = eg_in_i.sof ? (s_ff.cfg[B_CTRLQ] & eg_in_i.ctrl) : s_ff.wq;
         nxt_s.wq = wq; // [R9] [R11]
         if (eg_in_i.sof) begin
            drop = wq ? (qfr[1] < (EAW+1)'(CTRL_RES)) :
               (qfr[0] < (EAW+1)'(JUMBO_WORDS)); // [R5]
         end else begin
            drop = s_ff.wdrop[wq] || qfr[wq] == '0;
         end
         if (drop && (eg_in_i.sof || !s_ff.wdrop[wq])) begin
            inc[(wq ? C_CQ : C_DQ) + K_OVF] = 1'b1; // [R20] [R21]
         end
         nxt_s.wdrop[wq] = drop;
         if (!drop) begin
            e_we = 1'b1; // [R2]
            e_wa = s_ff.wp[wq];
            e_wd = enc(eg_in_i, s_ff.cfg[B_INJ]); // [R23]
            nxt_s.wp[wq] = enx(s_ff.wp[wq], s_ff.qe[wq], s_ff.qs[wq]);
            wr_d[wq] = 1'b1;
            wr_f[wq] = eg_in_i.eof;
         end
      end

      // Pause reaction
      if (s_ff.paused) begin
         if (s_ff.timer == '0) begin
            nxt_s.paused = 1'b0; // [R27]
         end else begin
            nxt_s.timer = s_ff.timer - 1'b1; // [R27]
         end
      end
      if (s_ff.pend && !s_ff.in_frm) begin
         nxt_s.pend = 1'b0;
         nxt_s.paused = 1'b1; // [R1]
         nxt_s.timer = TW'(s_ff.pq) * TW'(PAUSE_CYC); // [R26]
      end
      if (rx_pause_valid_i) begin
         if (rx_pause_quanta_i == '0) begin
            nxt_s.pend = 1'b0; // [R27]
            nxt_s.paused = 1'b0;
            nxt_s.timer = '0;
         end else if (s_ff.paused) begin
            nxt_s.timer = TW'(rx_pause_quanta_i) * TW'(PAUSE_CYC); // [R27]
         end else begin
            nxt_s.pend = 1'b1; // [R1]
            nxt_s.pq = rx_pause_quanta_i;
         end
      end
      if (!s_ff.cfg[B_REACT]) begin
         nxt_s.pend = 1'b0; // [R6]
         nxt_s.paused = 1'b0;
      end

      // Egress drain
      if (s_ff.gap != '0) begin
         nxt_s.gap = s_ff.gap - 1'b1; // [R16]
      end
      // Gap runs from the eof pop, even when that pop was stalled
      if (s_ff.eov && macsec_ready_i) begin
         nxt_s.eov = 1'b0;
         if (s_ff.eo.eof) begin
            nxt_s.gap = macsec_expand_i; // [R16]
         end
      end
      if (s_ff.eee == EEE_ACT && s_ff.gap == '0 && (!s_ff.eov ||
            (macsec_ready_i && !s_ff.eo.eof) ||
            (macsec_ready_i && macsec_expand_i == '0))) begin // [R16] [R17]
         if (s_ff.in_frm) begin
            rgo = 1'b1;
         end else if (s_ff.cfg[B_CTRLQ] && st[1]) begin
            rgo = 1'b1; // [R9] [R10]
            rq = 1'b1;
         end else if (!nxt_s.paused && st[0]) begin
            rgo = 1'b1; // [R2]
            rq = 1'b0;
         end
      end
      if (rgo) begin
         nxt_s.sel = rq;
         nxt_s.eov = 1'b1;
         if (s_ff.fill[rq] == '0) begin
            nxt_s.eo = '0; // [R20] [R21]
            nxt_s.eo.eof = 1'b1;
            nxt_s.eo.abort = 1'b1;
            inc[(rq ? C_CQ : C_DQ) + K_UDF] = 1'b1;
            nxt_s.skip[rq] = 1'b1;
         end else begin
            w = eg_mem[s_ff.rp[rq]];
            nxt_s.eo = dec(w);
            rd_d[rq] = 1'b1;
            rd_f[rq] = dec(w).eof;
            nxt_s.rp[rq] = enx(s_ff.rp[rq], s_ff.qe[rq], s_ff.qs[rq]);
            if (^w) begin
               nxt_s.eo.eof = 1'b1; // [R23]
               nxt_s.eo.abort = 1'b1;
               inc[(rq ? C_CQ : C_DQ) + K_ECC] = 1'b1;
               nxt_s.skip[rq] = !dec(w).eof;
            end
         end
         nxt_s.in_frm = !nxt_s.eo.eof;
      end
      // Discard the tail of an aborted frame as it arrives
      for (int q = 0; q < 2; q++) begin
         if (s_ff.skip[q] && s_ff.fill[q] != '0) begin
            rd_d[q] = 1'b1;
            rd_f[q] = dec(eg_mem[s_ff.rp[q]]).eof;
            nxt_s.skip[q] = !rd_f[q];
            nxt_s.rp[q] = enx(s_ff.rp[q], s_ff.qe[q], s_ff.qs[q]);
         end
         nxt_s.fill[q] = s_ff.fill[q] + (EAW+1)'(wr_d[q])
            - (EAW+1)'(rd_d[q]);
         nxt_s.frm[q] = s_ff.frm[q] + FW'(wr_f[q]) - FW'(rd_f[q]);
      end

      // Bound writes flush that queue
      if (wr_i && (addr_i == R_DQB || addr_i == R_CQB)) begin
         wq = (addr_i == R_CQB);
         nxt_s.qs[wq] = EAW'(wdata_i[FW-1:0]); // [R11]
         nxt_s.qe[wq] = EAW'(wdata_i[2*FW-1:FW]);
         nxt_s.wp[wq] = EAW'(wdata_i[FW-1:0]);
         nxt_s.rp[wq] = EAW'(wdata_i[FW-1:0]);
         nxt_s.fill[wq] = '0;
         nxt_s.frm[wq] = '0;
         nxt_s.skip[wq] = 1'b0;
      end

      // Thresholds, capped so a jumbo still fits above XOFF
      lim = (qsz[0] > (EAW+1)'(JUMBO_WORDS)) ?
         qsz[0] - (EAW+1)'(JUMBO_WORDS) : '0; // [R5]
      xe = (s_ff.xoff < lim) ? s_ff.xoff : lim;
      if (s_ff.fill[0] >= xe) begin
         nxt_s.thr = 1'b1; // [R4]
      end else if (s_ff.fill[0] <= s_ff.xon) begin
         nxt_s.thr = 1'b0; // [R4]
      end
      nxt_s.req = s_ff.cfg[B_GEN] && (s_ff.thr || (s_ff.cfg[B_MERGE] &&
         s_ff.cfg[B_REACT] && s_ff.paused)); // [R3] [R7] [R8]

      // EEE: enter LPI after idle_thr+1 empty cycles, wait wake_thr+1 to drain
      unique case (s_ff.eee)
         EEE_ACT: begin
            if (s_ff.cfg[B_EEE] && s_ff.fill == '0 && !s_ff.eov &&
                  !s_ff.in_frm) begin
               nxt_s.ecnt = s_ff.ecnt + 1'b1;
               if (s_ff.ecnt >= s_ff.idle_thr) begin
                  nxt_s.eee = EEE_LPI; // [R17]
                  nxt_s.ecnt = '0;
               end
            end else begin
               nxt_s.ecnt = '0;
            end
         end
         EEE_LPI: begin
            if (!s_ff.cfg[B_EEE] || s_ff.fill != '0) begin
               nxt_s.eee = EEE_WAKE; // [R17]
            end
         end
         EEE_WAKE: begin
            nxt_s.ecnt = s_ff.ecnt + 1'b1;
            if (s_ff.ecnt >= s_ff.wake_thr) begin
               nxt_s.eee = EEE_ACT;
               nxt_s.ecnt = '0;
            end
         end
         default: nxt_s.eee = EEE_ACT;
      endcase

      // Ingress: holds line frames while the host MAC inserts pauses
      if (ing_in_valid_i) begin
         drop = ing_in_i.sof ? (ifr < (IAW+1)'(ING_RES)) :
            (s_ff.iwdrop || ifr == '0); // [R14] [R18]
         if (drop && (ing_in_i.sof || !s_ff.iwdrop)) begin
            inc[C_IN + K_OVF] = 1'b1; // [R22]
         end
         nxt_s.iwdrop = drop;
         if (!drop) begin
            i_we = 1'b1; // [R15]
            i_wa = s_ff.iwp;
            i_wd = enc(ing_in_i, s_ff.cfg[B_INJ]);
            nxt_s.iwp = IAW'((32'(s_ff.iwp) + 1) % ING_DEPTH);
            iwr = 1'b1;
            iwf = ing_in_i.eof;
         end
      end
      if (s_ff.iov && ing_ready_i) begin
         nxt_s.iov = 1'b0;
      end
      if ((!s_ff.iov || ing_ready_i) && (s_ff.iin || (!s_ff.iskip &&
            (s_ff.ifrm != '0 || (s_ff.cut != '0 &&
            s_ff.ifill >= (IAW+1)'(s_ff.cut)))))) begin
         nxt_s.iov = 1'b1;
         if (s_ff.ifill == '0) begin
            nxt_s.io = '0;
            nxt_s.io.eof = 1'b1;
            nxt_s.io.abort = 1'b1;
            inc[C_IN + K_UDF] = 1'b1; // [R22]
            nxt_s.iskip = 1'b1;
         end else begin
            w = ing_mem[s_ff.irp];
            nxt_s.io = dec(w);
            ird = 1'b1;
            irf = dec(w).eof;
            if (^w) begin
               nxt_s.io.eof = 1'b1;
               nxt_s.io.abort = 1'b1;
               inc[C_IN + K_ECC] = 1'b1; // [R22] [R23]
               nxt_s.iskip = !dec(w).eof;
            end
         end
         nxt_s.iin = !nxt_s.io.eof;
      end else if (s_ff.iskip && s_ff.ifill != '0) begin
         ird = 1'b1;
         irf = dec(ing_mem[s_ff.irp]).eof;
         nxt_s.iskip = !irf;
      end
      if (ird) begin
         nxt_s.irp = IAW'((32'(s_ff.irp) + 1) % ING_DEPTH);
      end
      nxt_s.ifill = s_ff.ifill + (IAW+1)'(iwr) - (IAW+1)'(ird);
      nxt_s.ifrm = s_ff.ifrm + FW'(iwf) - FW'(irf);

      for (int i = 0; i < NCNT; i++) begin
         nxt_s.cnt[i] = s_ff.cnt[i] + 32'(inc[i]); // [R19]
      end
      // A new event in the clearing cycle stays set
      nxt_s.sticky = ((wr_i && addr_i == R_STICKY) ?
         s_ff.sticky & ~wdata_i[NCNT-1:0] : s_ff.sticky) | inc; // [R24]

      nxt_s.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            R_CFG: nxt_s.rdata = 32'(s_ff.cfg);
            R_XOFF: nxt_s.rdata = 32'(s_ff.xoff);
            R_XON: nxt_s.rdata = 32'(s_ff.xon);
            R_CUT: nxt_s.rdata = 32'(s_ff.cut);
            R_DQB: nxt_s.rdata = {FW'(s_ff.qe[0]), FW'(s_ff.qs[0])};
            R_CQB: nxt_s.rdata = {FW'(s_ff.qe[1]), FW'(s_ff.qs[1])};
            R_EEE: nxt_s.rdata = {s_ff.wake_thr, s_ff.idle_thr};
            R_STAT: nxt_s.rdata = {FW'(s_ff.fill[0]), 11'h000,
               s_ff.eee == EEE_LPI, s_ff.req, s_ff.thr, s_ff.pend,
               s_ff.paused};
            R_STICKY: nxt_s.rdata = 32'(s_ff.sticky);
            R_MASK: nxt_s.rdata = 32'(s_ff.mask);
            default: begin
               if (addr_i >= R_CNT0 &&
                     addr_i < R_CNT0 + 8'(4 * NCNT)) begin
                  nxt_s.rdata = s_ff.cnt[(addr_i - R_CNT0) >> 2];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_ff <= '0;
         s_ff.cfg <= CFG_RST;
         s_ff.xoff <= (EAW+1)'(XOFF_RST);
         s_ff.xon <= (EAW+1)'(XON_RST);
         s_ff.qe[0] <= EAW'(EG_DEPTH - CQ_WORDS - 1); // [R13]
         s_ff.qs[1] <= EAW'(EG_DEPTH - CQ_WORDS);
         s_ff.wp[1] <= EAW'(EG_DEPTH - CQ_WORDS);
         s_ff.rp[1] <= EAW'(EG_DEPTH - CQ_WORDS);
         s_ff.qe[1] <= EAW'(EG_DEPTH - 1);
         s_ff.idle_thr <= IDLE_RST;
         s_ff.wake_thr <= WAKE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Memories carry no reset; contents are valid only behind the pointers
   always_ff @(posedge clk_i) begin
      if (e_we) begin
         eg_mem[e_wa] <= e_wd;
      end
      if (i_we) begin
         ing_mem[i_wa] <= i_wd;
      end
   end

   assign rdata_o = s_ff.rdata;
   assign eg_out_o = s_ff.eo;
   assign eg_out_valid_o = s_ff.eov;
   assign ing_out_o = s_ff.io;
   assign ing_out_valid_o = s_ff.iov;
   assign pause_frame_request_o = s_ff.req;
   assign lpi_o = (s_ff.eee == EEE_LPI);
   assign irq_o = |(s_ff.sticky & s_ff.mask); // [R24]
endmodule
`default_nettype wire

// [pkg/fcb_pkg.sv]
// Package for the flow control frame buffer: word format, register map,
// configuration bits and sizing constants.
// Assumes a 64-bit packet word path on a single 10 MHz core clock.
package fcb_pkg;
   localparam int DW = 64;

   typedef struct packed {
      logic [DW-1:0] data;
      logic sof;
      logic eof;
      logic ctrl;
      logic special;
      logic abort;
   } fcb_word_s;

   typedef enum logic [1:0] {EEE_ACT, EEE_LPI, EEE_WAKE} fcb_eee_e;

   // Pause quanta are 512 bit times; one word carries DW bits
   localparam int QUANTUM_BITS = 512;
   localparam int PAUSE_CYC = QUANTUM_BITS / DW;

   localparam int WORD_BYTES = DW / 8;
   localparam int JUMBO_BYTES = 10240;
   localparam int JUMBO_WORDS = JUMBO_BYTES / WORD_BYTES;
   localparam int MTU_FRAMES = 4;
   localparam int EG_DEPTH_DEF = MTU_FRAMES * JUMBO_WORDS;
   localparam int CQ_WORDS = 512;
   localparam int CTRL_BYTES = 1522;
   localparam int CTRL_RES = (CTRL_BYTES + WORD_BYTES - 1) / WORD_BYTES;
   localparam int ING_DEPTH_DEF = 2 * JUMBO_WORDS;
   localparam int ING_RES = JUMBO_WORDS;

   localparam logic [7:0] R_CFG = 8'h00;
   localparam logic [7:0] R_XOFF = 8'h04;
   localparam logic [7:0] R_XON = 8'h08;
   localparam logic [7:0] R_CQB = 8'h0C;
   localparam logic [7:0] R_DQB = 8'h10;
   localparam logic [7:0] R_CUT = 8'h14;
   localparam logic [7:0] R_EEE = 8'h18;
   localparam logic [7:0] R_STAT = 8'h1C;
   localparam logic [7:0] R_STICKY = 8'h20;
   localparam logic [7:0] R_MASK = 8'h24;
   localparam logic [7:0] R_CNT0 = 8'h40;

   localparam int B_REACT = 0;
   localparam int B_GEN = 1;
   localparam int B_MERGE = 2;
   localparam int B_CTRLQ = 3;
   localparam int B_EEE = 4;
   localparam int B_INJ = 5;
   localparam logic [7:0] CFG_RST = 8'h0F;

   localparam int FW = 16;
   localparam int ST_FILL = 16;
   localparam logic [15:0] XOFF_RST = 16'h0800;
   localparam logic [15:0] XON_RST = 16'h0400;
   localparam logic [15:0] IDLE_RST = 16'h0040;
   localparam logic [15:0] WAKE_RST = 16'h0010;

   // Counter order: ctrl queue, data queue, ingress; each ovf, udf, ecc
   localparam int NCNT = 9;
   localparam int C_CQ = 0;
   localparam int C_DQ = 3;
   localparam int C_IN = 6;
   localparam int K_OVF = 0;
   localparam int K_UDF = 1;
   localparam int K_ECC = 2;
endpackage

// [dv/fcb_far_model.sv]
// Far-side stand-in: MACsec ready pacing, expansion gap, host ready.
// Assumes the bench steers the stall and slow pacing inputs.
`timescale 1ns/1ps
`default_nettype none
module fcb_far_model #(
   parameter logic [7:0] EXPAND = 8'h02
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic stall_i,
   input wire logic slow_i,
   output logic macsec_ready_o,
   output logic [7:0] macsec_expand_o,
   output logic ing_ready_o
);
   logic [1:0] cnt_ff;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end
   // Slow pacing takes one beat in four, like a busy transform engine
   assign macsec_ready_o = !stall_i && (!slow_i || cnt_ff == 2'h0);
   assign macsec_expand_o = EXPAND;
   // Host side refuses every other beat so the ingress output must wait
   assign ing_ready_o = !stall_i && !cnt_ff[0];
endmodule
`default_nettype wire

// [dv/fcb_chk.sv]
// Port checker for the flow control frame buffer top.
// Assumes config and mask change only through bus writes.
`timescale 1ns/1ps
`default_nettype none
module fcb_chk
   import fcb_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire fcb_word_s eg_out_o,
   input wire logic eg_out_valid_o,
   input wire logic macsec_ready_i,
   input wire logic [7:0] macsec_expand_i,
   input wire logic rx_pause_valid_i,
   input wire logic [15:0] rx_pause_quanta_i,
   input wire logic pause_frame_request_o,
   input wire logic lpi_o,
   input wire fcb_word_s ing_out_o,
   input wire logic ing_out_valid_o,
   input wire logic ing_ready_i,
   input wire logic irq_o
);
   logic [7:0] cfg_ff;
   logic [31:0] mask_ff;
   // Shadow copies of what software wrote
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_ff <= CFG_RST;
         mask_ff <= 32'h0000_0000;
      end else if (wr_i && addr_i == R_CFG) begin
         cfg_ff <= wdata_i[7:0];
      end else if (wr_i && addr_i == R_MASK) begin
         mask_ff <= wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data outside its slot");
   eg_hold_a: assert property (eg_out_valid_o && !macsec_ready_i |=>
      eg_out_valid_o && $stable(eg_out_o)) else $error("egress word lost");
   ing_hold_a: assert property (ing_out_valid_o && !ing_ready_i |=>
      ing_out_valid_o && $stable(ing_out_o)) else $error("ingress word lost");
   gen_off_a: assert property (!cfg_ff[B_GEN] |=> !pause_frame_request_o)
      else $error("pause request while generation off");
   pause_req_a: assert property (rx_pause_valid_i &&
      rx_pause_quanta_i >= 16'h0010 && cfg_ff[2:0] == 3'h7 |->
      ##[1:1000] pause_frame_request_o) else $error("no request when paused");
   exp_gap_a: assert property (eg_out_valid_o && macsec_ready_i &&
      eg_out_o.eof && macsec_expand_i != 8'h00 |=> !eg_out_valid_o)
      else $error("no gap after expanded frame");
   eee_off_a: assert property (!cfg_ff[B_EEE] |=> !lpi_o)
      else $error("low power idle while disabled");
   irq_mask_a: assert property (mask_ff == 32'h0000_0000 |-> !irq_o)
      else $error("interrupt with all events masked");
endmodule
bind fcb_top fcb_chk u_chk (.*);
`default_nettype wire

// [dv/flow_control_frame_buffer_test.sv]
// Self-checking bench for the flow control frame buffer top.
// Assumes the far model paces MACsec and host readiness.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
   fail_count++; $display("Error %s exp %0h got %0h", n, e, s); end end
module flow_control_frame_buffer_test;
   import fcb_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] e;} fcb_row_s;
   logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, macsec_expand_i;
   logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
   fcb_word_s eg_in_i = '0, ing_in_i = '0, eg_out_o, ing_out_o;
   logic eg_in_valid_i = 1'b0, ing_in_valid_i = 1'b0, rx_pause_valid_i = 1'b0;
   logic [15:0] rx_pause_quanta_i = 16'h0000;
   logic eg_out_valid_o, macsec_ready_i, pause_frame_request_o, lpi_o;
   logic ing_out_valid_o, ing_ready_i, irq_o, stall = 1'b0, slow = 1'b0;
   int fail_count = 0, cmp_count = 0, cyc = 0, t0;
   fcb_word_s eg_q[$], ing_q[$];
   int eg_t[$];
   fcb_row_s rows[11] = '{'{R_CFG, 32'h0000_000F},
      '{R_XOFF, {16'h0000, XOFF_RST}}, '{R_XON, {16'h0000, XON_RST}},
      '{R_CQB, 32'h13FF_1200}, '{R_DQB, 32'h11FF_0000},
      '{R_CUT, 32'h0000_0000}, '{R_EEE, {WAKE_RST, IDLE_RST}},
      '{R_STAT, 32'h0000_0000}, '{R_STICKY, 32'h0000_0000},
      '{R_MASK, 32'h0000_0000}, '{8'hFC, 32'h0000_0000}};
   fcb_top dut (.*);
   fcb_far_model far (.clk_i, .nrst_i, .stall_i(stall), .slow_i(slow),
      .macsec_ready_o(macsec_ready_i), .macsec_expand_o(macsec_expand_i),
      .ing_ready_o(ing_ready_i));
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (eg_out_valid_o && macsec_ready_i) eg_q.push_back(eg_out_o);
      if (eg_out_valid_o && macsec_ready_i && eg_out_o.sof) eg_t.push_back(cyc);
      if (ing_out_valid_o && ing_ready_i) ing_q.push_back(ing_out_o);
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      `CHK("register", e, rdata_o)
      @(posedge clk_i);
   endtask
   task automatic pz(input logic [15:0] q);
      rx_pause_quanta_i <= q;
      rx_pause_valid_i <= 1'b1;
      @(posedge clk_i);
      rx_pause_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pin(input logic e, input logic s);
      @(negedge clk_i);
      `CHK("pin", e, s)
      @(posedge clk_i);
   endtask
   function automatic fcb_word_s mkw(input bit c, input int i, n,
                                     input logic [7:0] t);
      mkw = '0;
      mkw.data = {t, 56'(i)};
      mkw.sof = (i == 0);
      mkw.eof = (i == n - 1);
      mkw.ctrl = c;
   endfunction
   task automatic send(input bit ing, c, input int n, input logic [7:0] t);
      for (int i = 0; i < n; i++) begin
         if (ing) ing_in_i <= mkw(c, i, n, t);
         else eg_in_i <= mkw(c, i, n, t);
         ing_in_valid_i <= ing;
         eg_in_valid_i <= !ing;
         @(posedge clk_i);
      end
      ing_in_valid_i <= 1'b0;
      eg_in_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic expf(input bit ing, c, input int n, input logic [7:0] t);
      fcb_word_s w;
      for (int k = 0; k < 3000 && (ing ? ing_q.size() : eg_q.size()) < n; k++)
         @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         w = ing ? ing_q.pop_front() : eg_q.pop_front();
         `CHK("word", mkw(c, i, n, t), w)
      end
   endtask
   // Pause then clear or ignore it; data must still leave promptly
   task automatic quick(input logic [31:0] cfg, input logic [15:0] q);
      wr(R_CFG, cfg);
      pz(16'h0100);
      pz(q);
      eg_t.delete();
      t0 = cyc;
      send(0, 0, 2, 8'h71);
      expf(0, 0, 2, 8'h71);
      `CHK("latency", 1'b1, eg_t[0] - t0 <= 12)
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      for (int i = 0; i < NCNT; i++) rd(R_CNT0 + 8'(4 * i), 32'h0000_0000);
      slow <= 1'b1;
      send(0, 0, 5, 8'h11);
      expf(0, 0, 5, 8'h11);
      slow <= 1'b0;
      send(1, 0, 4, 8'h21);
      expf(1, 0, 4, 8'h21);
      stall <= 1'b1;
      send(0, 0, 2, 8'h41);
      send(0, 0, 2, 8'h42);
      send(0, 1, 2, 8'h43);
      stall <= 1'b0;
      expf(0, 0, 2, 8'h41);
      expf(0, 1, 2, 8'h43);
      expf(0, 0, 2, 8'h42);
      eg_t.delete();
      pz(16'h0010);
      t0 = cyc;
      send(0, 0, 3, 8'h31);
      send(0, 1, 2, 8'h32);
      pin(1'b1, pause_frame_request_o);
      expf(0, 1, 2, 8'h32);
      expf(0, 0, 3, 8'h31);
      `CHK("pause", 1'b1, (eg_t[1] - t0) inside {[128:145]})
      wr(R_CFG, 32'h0000_000D);
      pz(16'h0010);
      pin(1'b0, pause_frame_request_o);
      pz(16'h0000);
      wr(R_CFG, 32'h0000_000B);
      pz(16'h0010);
      pin(1'b0, pause_frame_request_o);
      pz(16'h0000);
      quick(32'h0000_000F, 16'h0000);
      quick(32'h0000_0002, 16'h0100);
      wr(R_CFG, 32'h0000_000F);
      wr(R_XOFF, 32'h0000_0008);
      wr(R_XON, 32'h0000_0004);
      stall <= 1'b1;
      send(0, 0, 10, 8'h61);
      pin(1'b1, pause_frame_request_o);
      stall <= 1'b0;
      expf(0, 0, 10, 8'h61);
      repeat (4) @(posedge clk_i);
      pin(1'b0, pause_frame_request_o);
      stall <= 1'b1;
      for (int k = 0; k < 5; k++) send(0, 1, 100, 8'(8'h50 + k));
      stall <= 1'b0;
      for (int k = 0; k < 4; k++) expf(0, 1, 100, 8'(8'h50 + k));
      rd(R_CNT0, 32'h0000_0001);
      rd(R_STICKY, 32'h0000_0001);
      wr(R_MASK, 32'h0000_0001);
      pin(1'b1, irq_o);
      wr(R_STICKY, 32'h0000_0001);
      pin(1'b0, irq_o);
      final_report();
   end
endmodule
`default_nettype wire
